/* File: rx_irq_pkg.sv */
// Register map, field layout and codes for the receiver irq mode and output one select block
package rx_irq_pkg;
  localparam logic [7:0] mode_two_addr = 8'h19;
  localparam logic [7:0] mode_three_addr = 8'h1a;
  localparam logic [7:0] pin_one_addr = 8'h1b;
  localparam logic [7:0] mode_two_reset = 8'h00;
  localparam logic [1:0] mode_three_reset = 2'h0;
  localparam logic [3:0] pin_one_reset = 4'h0;
  localparam int crc_pos = 6;
  localparam int parity_pos = 4;
  localparam int validity_pos = 2;
  localparam int biphase_pos = 0;
  localparam int slip_pos = 0;
  localparam int select_pos = 0;
  localparam int src_count = 6;
  localparam int src_crc = 0;
  localparam int src_parity = 1;
  localparam int src_validity = 2;
  localparam int src_biphase = 3;
  localparam int src_slip = 4;
  localparam int src_buffer = 5;
  typedef enum logic [1:0] {
    mode_rise = 2'b00,
    mode_fall = 2'b01,
    mode_level = 2'b10,
    mode_reserved = 2'b11
  } irq_mode_type;
  typedef enum logic [3:0] {
    sel_low = 4'b0000,
    sel_high = 4'b0001,
    sel_src_irq = 4'b0010,
    sel_tx_irq = 4'b0011,
    sel_rx_irq = 4'b0100,
    sel_preemph = 4'b0101,
    sel_non_audio = 4'b0110,
    sel_non_valid = 4'b0111,
    sel_chan_status = 4'b1000,
    sel_user_data = 4'b1001,
    sel_block_start = 4'b1010,
    sel_copy = 4'b1011,
    sel_generation = 4'b1100,
    sel_parity = 4'b1101,
    sel_rx_sync = 4'b1110,
    sel_tx_sync = 4'b1111
  } pin_select_type;
endpackage

/* File: irq_flag_detect.sv */
// One interrupt source: edge or level detection per two-bit mode
`timescale 1ns/1ps
module irq_flag_detect (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [1:0] mode,
  input wire logic condition,
  output logic flag
);
  logic last;
  logic next_flag;
  wire rise_seen = condition & ~last;
  wire fall_seen = ~condition & last;
  always_comb begin
    case (rx_irq_pkg::irq_mode_type'(mode))
      rx_irq_pkg::mode_rise: next_flag = rise_seen;
      rx_irq_pkg::mode_fall: next_flag = fall_seen;
      rx_irq_pkg::mode_level: next_flag = condition;
      default: next_flag = 1'b0;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      last <= 1'b0;
      flag <= 1'b0;
    end else begin
      last <= condition;
      flag <= next_flag;
    end
  end
endmodule

/* File: rx_irq_mode_and_gpo_select.sv */
// Receiver interrupt mode registers, per-source flag detection and output pin one selection
// How it works
// - Mode codes: rise, fall, level, reserved
// - Mode two: crc, parity, validity, biphase fields
// - Select field bits 3:0, upper bits zero
// - Code 0 low default, 1 high
// - Code 2: converter interrupt, active low
// - Code 3: transmitter interrupt, active low
// - Code 4: receiver interrupt, active low
// - Code 5: pre-emphasis flag, low when set
// - Code 6: non-audio, high when set
// - Code 7: non-valid, high when set
// - Code 8: channel status bit stream
// - Code 9: user data bit stream
// - Code 10: block start clock
// - Code 11: copy bit, low asserted
// - Code 12: generation bit, low not original
// - Code 13: parity error, active high
// - Code 14: receiver sync clock
// - Code 15: transmitter sync clock
`timescale 1ns/1ps
module rx_irq_mode_and_gpo_select (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic reg_write,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [1:0] buffer_transfer_irq_mode,
  input wire logic chan_crc_err,
  input wire logic parity_err,
  input wire logic validity_err,
  input wire logic biphase_err,
  input wire logic output_slip_err,
  input wire logic buffer_transfer,
  output logic [5:0] source_flags,
  input wire logic src_irq_n,
  input wire logic tx_irq_n,
  input wire logic rx_irq_n,
  input wire logic preemph_set,
  input wire logic non_audio,
  input wire logic non_valid,
  input wire logic chan_status_bit,
  input wire logic user_data_bit,
  input wire logic block_start_clk,
  input wire logic copy_bit,
  input wire logic generation_bit,
  input wire logic rx_sync_clk,
  input wire logic tx_sync_clk,
  output logic general_output_pin_one
);
  logic [7:0] mode_two;
  logic [1:0] mode_three;
  logic [3:0] output_pin_one_source_select;
  logic next_pin;

  // Register writes take effect on the next edge
  wire wr_two = reg_write && (reg_addr == rx_irq_pkg::mode_two_addr);
  wire wr_three = reg_write && (reg_addr == rx_irq_pkg::mode_three_addr);
  wire wr_pin = reg_write && (reg_addr == rx_irq_pkg::pin_one_addr);

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      mode_two <= rx_irq_pkg::mode_two_reset;
      mode_three <= rx_irq_pkg::mode_three_reset;
      output_pin_one_source_select <= rx_irq_pkg::pin_one_reset;
    end else begin
      if (wr_two)
        mode_two <= reg_wdata;
      if (wr_three)
        mode_three <= reg_wdata[1:0];
      if (wr_pin)
        output_pin_one_source_select <= reg_wdata[3:0];
    end
  end

  // Read data is combinational from the address; fixed-zero bits read zero
  wire [7:0] rd_two = mode_two;
  wire [7:0] rd_three = {6'h00, mode_three};
  wire [7:0] rd_pin = {4'h0, output_pin_one_source_select};
  always_comb begin
    case (reg_addr)
      rx_irq_pkg::mode_two_addr: reg_rdata = rd_two;
      rx_irq_pkg::mode_three_addr: reg_rdata = rd_three;
      rx_irq_pkg::pin_one_addr: reg_rdata = rd_pin;
      default: reg_rdata = 8'h00;
    endcase
  end

  // Field extraction per source
  wire [1:0] crc_mode = mode_two[rx_irq_pkg::crc_pos +: 2];
  wire [1:0] parity_mode = mode_two[rx_irq_pkg::parity_pos +: 2];
  wire [1:0] validity_mode = mode_two[rx_irq_pkg::validity_pos +: 2];
  wire [1:0] biphase_mode = mode_two[rx_irq_pkg::biphase_pos +: 2];
  wire [1:0] slip_mode = mode_three[rx_irq_pkg::slip_pos +: 2];

  wire [rx_irq_pkg::src_count*2-1:0] modes = {buffer_transfer_irq_mode, slip_mode, biphase_mode,
    validity_mode, parity_mode, crc_mode};
  wire [rx_irq_pkg::src_count-1:0] conds = {buffer_transfer, output_slip_err, biphase_err,
    validity_err, parity_err, chan_crc_err};

  // Reserved mode code leaves the source silent rather than guessing a behaviour
  genvar i;
  generate
    for (i = 0; i < rx_irq_pkg::src_count; i = i + 1) begin : g_src
      irq_flag_detect irq_flag_detect_i (
        .mclk(mclk),
        .nrst(nrst),
        .mode(modes[i*2 +: 2]),
        .condition(conds[i]),
        .flag(source_flags[i])
      );
    end
  endgenerate

  // Source inputs are same-clock logic, so no synchroniser; pin is registered to stay glitch free
  always_comb begin
    case (rx_irq_pkg::pin_select_type'(output_pin_one_source_select))
      rx_irq_pkg::sel_low: next_pin = 1'b0;
      rx_irq_pkg::sel_high: next_pin = 1'b1;
      rx_irq_pkg::sel_src_irq: next_pin = src_irq_n;
      rx_irq_pkg::sel_tx_irq: next_pin = tx_irq_n;
      rx_irq_pkg::sel_rx_irq: next_pin = rx_irq_n;
      rx_irq_pkg::sel_preemph: next_pin = ~preemph_set;
      rx_irq_pkg::sel_non_audio: next_pin = non_audio;
      rx_irq_pkg::sel_non_valid: next_pin = non_valid;
      rx_irq_pkg::sel_chan_status: next_pin = chan_status_bit;
      rx_irq_pkg::sel_user_data: next_pin = user_data_bit;
      rx_irq_pkg::sel_block_start: next_pin = block_start_clk;
      rx_irq_pkg::sel_copy: next_pin = copy_bit;
      rx_irq_pkg::sel_generation: next_pin = generation_bit;
      rx_irq_pkg::sel_parity: next_pin = parity_err;
      rx_irq_pkg::sel_rx_sync: next_pin = rx_sync_clk;
      rx_irq_pkg::sel_tx_sync: next_pin = tx_sync_clk;
      default: next_pin = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst)
      general_output_pin_one <= 1'b0;
    else
      general_output_pin_one <= next_pin;
  end
endmodule

/* File: rx_irq_mode_and_gpo_select_checker.sv */
// Checker for the receiver irq mode and output pin one select block
`timescale 1ns/1ps
module rx_irq_mode_and_gpo_select_checker (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic reg_write,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic chan_crc_err,
  input wire logic parity_err,
  input wire logic validity_err,
  input wire logic [5:0] source_flags,
  input wire logic preemph_set,
  input wire logic general_output_pin_one
);
  // Shadow copies of the registers, rebuilt from the write port
  logic [7:0] m2;
  logic [1:0] m3;
  logic [3:0] sel;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      m2 <= 8'h00;
      m3 <= 2'h0;
      sel <= 4'h0;
    end else if (reg_write) begin
      if (reg_addr == 8'h19) m2 <= reg_wdata;
      if (reg_addr == 8'h1a) m3 <= reg_wdata[1:0];
      if (reg_addr == 8'h1b) sel <= reg_wdata[3:0];
    end
  end
  sequence crc_rise; m2[7:6] == 2'b00 && $rose(chan_crc_err); endsequence
  sequence par_fall; m2[5:4] == 2'b01 && $fell(parity_err); endsequence
  a_crc_rise: assert property (crc_rise |=> source_flags[0]) else $error("no crc flag");
  a_par_fall: assert property (par_fall |=> source_flags[1]) else $error("no parity flag");
  a_level_follow: assert property (m2[3:2] == 2'b10 |=> source_flags[2] == $past(validity_err))
    else $error("level flag wrong");
  a_slip_reserved: assert property (m3 == 2'b11 |=> !source_flags[4]) else $error("reserved flag");
  a_edge_once: assert property (m2[1:0] == 2'b00 && source_flags[3] |=> !source_flags[3])
    else $error("edge flag held");
  a_pin_low: assert property (sel == 4'h0 |=> !general_output_pin_one) else $error("pin not low");
  a_pin_high: assert property (sel == 4'h1 |=> general_output_pin_one) else $error("pin not high");
  a_pin_preemph: assert property (sel == 4'h5 |=> general_output_pin_one == !$past(preemph_set))
    else $error("preemph pin wrong");
endmodule
bind rx_irq_mode_and_gpo_select rx_irq_mode_and_gpo_select_checker chk_i (.mclk, .nrst, .reg_write,
  .reg_addr, .reg_wdata, .chan_crc_err, .parity_err, .validity_err, .source_flags, .preemph_set,
  .general_output_pin_one);

/* File: pin_watcher.sv */
// Model of the outside logic that samples output pin one
`timescale 1ns/1ps
module pin_watcher (
  input wire logic mclk,
  input wire logic pin,
  output logic seen
);
  // A synchronous consumer sees the pin one clock late
  always_ff @(posedge mclk) seen <= pin;
endmodule

/* File: rx_irq_mode_and_gpo_select_tb.sv */
// Self-checking bench for the receiver irq mode and output pin one select block
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; $display("ERROR %0t %h %h", $time, a, e); end end
module rx_irq_mode_and_gpo_select_tb;
  logic mclk = 1'b0, nrst = 1'b0, reg_write = 1'b0, seen, general_output_pin_one;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [1:0] buffer_transfer_irq_mode = 2'h0;
  logic [5:0] cond = 6'h00, source_flags;
  logic [12:0] srcs = 13'h0000;
  int bad_count = 0, checks_done = 0;
  rx_irq_mode_and_gpo_select rx_irq_mode_and_gpo_select_i (.mclk, .nrst, .reg_write, .reg_addr,
    .reg_wdata, .reg_rdata, .buffer_transfer_irq_mode, .source_flags, .general_output_pin_one,
    .chan_crc_err(cond[0]), .parity_err(cond[1]), .validity_err(cond[2]), .biphase_err(cond[3]),
    .output_slip_err(cond[4]), .buffer_transfer(cond[5]), .src_irq_n(srcs[0]), .tx_irq_n(srcs[1]),
    .rx_irq_n(srcs[2]), .preemph_set(srcs[3]), .non_audio(srcs[4]), .non_valid(srcs[5]),
    .chan_status_bit(srcs[6]), .user_data_bit(srcs[7]), .block_start_clk(srcs[8]), .copy_bit(srcs[9]),
    .generation_bit(srcs[10]), .rx_sync_clk(srcs[11]), .tx_sync_clk(srcs[12]));
  pin_watcher pin_watcher_i (.mclk, .pin(general_output_pin_one), .seen);
  always #5 mclk = ~mclk;
  // Every task that drives the bus starts on an edge, so a strobe is never set and cleared in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    @(posedge mclk);
    #1 `CHK(reg_rdata, e)
  endtask
  task automatic t_regs();
    rd(8'h19, 8'h00);
    rd(8'h1a, 8'h00);
    rd(8'h1b, 8'h00);
    wr(8'h19, 8'ha5);
    rd(8'h19, 8'ha5);
    wr(8'h1a, 8'hff);
    rd(8'h1a, 8'h03);
    wr(8'h1b, 8'hff);
    rd(8'h1b, 8'h0f);
    wr(8'h1c, 8'h5a);
    rd(8'h1c, 8'h00);
  endtask
  // One-hot source pattern and its inverse tell a wrong selection apart
  task automatic t_pins();
    logic x;
    for (int c = 0; c < 16; c++) begin
      for (int v = 0; v < 2; v++) begin
        wr(8'h1b, 8'(c));
        // Code 13 watches the parity condition, and codes 14 and 15 sit one place lower in srcs
        srcs <= (c > 1) ? ((v == 1) ? ~(13'h1 << ((c < 13) ? c - 2 : c - 3))
          : (13'h1 << ((c < 13) ? c - 2 : c - 3))) : 13'h0000;
        cond <= (c == 13 && v == 0) ? 6'h02 : 6'h00;
        x = (c == 0) ? 1'b0 : (c == 1) ? 1'b1 : (c == 5) ? 1'(v) : !1'(v);
        repeat (3) @(posedge mclk);
        #1 `CHK(seen, x)
      end
    end
  endtask
  task automatic t_flags(input logic [7:0] m2, input logic [1:0] bm, input logic [5:0] e0, e1, e2);
    wr(8'h19, m2);
    wr(8'h1a, 8'h00);
    buffer_transfer_irq_mode <= bm;
    @(posedge mclk);
    cond <= 6'h3f;
    @(posedge mclk);
    #1 `CHK(source_flags, e0)
    @(posedge mclk);
    cond <= 6'h00;
    #1 `CHK(source_flags, e1)
    @(posedge mclk);
    #1 `CHK(source_flags, e2)
    @(posedge mclk);
    #1 `CHK(source_flags, 6'h00)
  endtask
  task automatic t_midreset();
    wr(8'h1b, 8'h01);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    rd(8'h1b, 8'h00);
    `CHK(seen, 1'b0)
  endtask
  task automatic give_verdict();
    if (bad_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    t_regs();
    t_pins();
    t_flags(8'h1b, 2'h1, 6'h15, 6'h04, 6'h22);
    t_flags(8'h6c, 2'h2, 6'h3a, 6'h22, 6'h01);
    t_midreset();
    give_verdict();
  end
  initial begin
    #20000;
    bad_count++;
    give_verdict();
  end
endmodule
